// *** core/amp_fault_status_mask.sv ***
// Fault and warning status bank with report masks and latch control.
`timescale 1ns/1ps
`default_nettype none
`include "amp_fault_cfg.svh"

// Behaviour
// - Channel status: DC and overcurrent flags, read-only.
// - Global one bit 7: OTP CRC failure.
// - Global one bit 6: biquad write failed.
// - Global one bit 5: EEPROM boot load failed.
// - Global two: right/left current-limit faults.
// - Global two bit 0: thermal shutdown.
// - Warning bits 5/4: current-limit warnings, 7-6 reserved.
// - Warning bits 3-0: four thermal warning levels.
// - Mask bit 7 hides thermal shutdown report.
// - Mask bits 6/5 hide logic supply faults.
// - Mask bit 4 hides clock fault; bit 3 reserved.
// - Mask bit 2 hides power supply faults.
// - Mask bits 1/0 hide DC/overcurrent; reset zero.
// - Latch control: five latch enables, three masks.
// - Clear register bit 7 clears latched faults.
module amp_fault_status_mask
  import amp_fault_pkg::*;
(
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // Register port
  input  wire reg_req_s        regReq,
  output logic                 rdValid,
  output reg_byte_t            rdData,
  // Monitor conditions, asynchronous
  input  wire fault_in_s       faultIn,
  input  wire warn_in_s        warnIn,
  // Digital status, control clock domain
  input  wire digital_status_s digitalStatus,
  // Reports
  output logic                 faultReport,
  output logic                 warnReport,
  output logic                 analogFaultClear
);

  localparam int FAULT_W = $bits(fault_in_s);
  localparam int WARN_W  = $bits(warn_in_s);

  // Synchronised monitor levels.
  fault_in_s faultSync;
  warn_in_s  warnSync;

  fault_sync #(
    .WIDTH  (FAULT_W),
    .STAGES (`SYNC_STAGES)
  ) uFaultSync (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (faultIn),
    .syncOut (faultSync)
  );

  fault_sync #(
    .WIDTH  (WARN_W),
    .STAGES (`SYNC_STAGES)
  ) uWarnSync (
    .clk     (clk),
    .srst    (srst),
    .asyncIn (warnIn),
    .syncOut (warnSync)
  );

  // Software registers.
  reg_byte_t maskCtl_reg;
  reg_byte_t maskCtl_next;
  reg_byte_t latchCtl_reg;
  reg_byte_t latchCtl_next;
  logic      clear_reg;
  logic      clear_next;
  logic      rdValid_reg;
  reg_byte_t rdData_reg;
  reg_byte_t rdData_next;

  // Address decode.
  wire selChannel = regReq.addr == `OFS_CHANNEL_FAULT_STATUS;
  wire selGlobal1 = regReq.addr == `OFS_GLOBAL_FAULT_STATUS_ONE;
  wire selGlobal2 = regReq.addr == `OFS_GLOBAL_FAULT_STATUS_TWO;
  wire selWarning = regReq.addr == `OFS_WARNING_STATUS;
  wire selMask    = regReq.addr == `OFS_FAULT_REPORT_MASK;
  wire selLatch   = regReq.addr == `OFS_FAULT_LATCH_CONTROL;
  wire selClear   = regReq.addr == `OFS_FAULT_CLEAR;

  // Writes to the status offsets match no write strobe, so they fall away unseen.
  wire wrMask  = regReq.wrEn & selMask;
  wire wrLatch = regReq.wrEn & selLatch;
  wire wrClear = regReq.wrEn & selClear;

  // The reserved mask bit is not stored, so it always reads zero.
  localparam reg_byte_t MASK_WRITABLE = ~(8'h01 << `BIT_MASK_RESERVED);

  assign maskCtl_next  = wrMask ? (regReq.wData & MASK_WRITABLE)
                                : maskCtl_reg;
  assign latchCtl_next = wrLatch ? regReq.wData : latchCtl_reg;
  // The clear is a self-clearing strobe; the stored byte never reads back.
  assign clear_next    = wrClear & regReq.wData[`BIT_ANALOG_FAULT_CLEAR];

  always_ff @(posedge clk) begin
    if (srst) begin
      maskCtl_reg  <= `RST_FAULT_REPORT_MASK;
      latchCtl_reg <= `RST_FAULT_LATCH_CONTROL;
      clear_reg    <= 1'b0;
    end else begin
      maskCtl_reg  <= maskCtl_next;
      latchCtl_reg <= latchCtl_next;
      clear_reg    <= clear_next;
    end
  end

  // Latch enables per fault bit. DC, overcurrent and supply faults are
  // always latched; the others follow the latch control register.
  wire latchCbcFault = latchCtl_reg[`BIT_LATCH_CBC_FAULT];
  wire latchCbcWarn  = latchCtl_reg[`BIT_LATCH_CBC_WARN];
  wire latchClock    = latchCtl_reg[`BIT_LATCH_CLOCK];
  wire latchThermSd  = latchCtl_reg[`BIT_LATCH_THERMAL_SD];
  wire latchThermW   = latchCtl_reg[`BIT_LATCH_THERMAL_WARN];

  fault_in_s faultLatchEn;
  warn_in_s  warnLatchEn;

  assign faultLatchEn = '{
    thermal_shutdown_flag          : latchThermSd,
    right_current_limit_fault_flag : latchCbcFault,
    left_current_limit_fault_flag  : latchCbcFault,
    logic_supply_overvoltage       : 1'b1,
    logic_supply_undervoltage      : 1'b1,
    clock_fault                    : latchClock,
    power_supply_overvoltage_flag  : 1'b1,
    power_supply_undervoltage_flag : 1'b1,
    left_dc_fault_flag             : 1'b1,
    right_dc_fault_flag            : 1'b1,
    left_overcurrent_flag          : 1'b1,
    right_overcurrent_flag         : 1'b1
  };

  assign warnLatchEn = '{
    left_current_limit_warning_flag  : latchCbcWarn,
    right_current_limit_warning_flag : latchCbcWarn,
    thermal_warning_level_four       : latchThermW,
    thermal_warning_level_three      : latchThermW,
    thermal_warning_level_two        : latchThermW,
    thermal_warning_level_one        : latchThermW
  };

  // Sticky flags; a condition still present at clear stays set.
  fault_in_s faultFlag;
  warn_in_s  warnFlag;

  fault_latch #(
    .WIDTH (FAULT_W)
  ) uFaultLatch (
    .clk     (clk),
    .srst    (srst),
    .live    (faultSync),
    .latchEn (faultLatchEn),
    .clear   (clear_reg),
    .flags   (faultFlag)
  );

  fault_latch #(
    .WIDTH (WARN_W)
  ) uWarnLatch (
    .clk     (clk),
    .srst    (srst),
    .live    (warnSync),
    .latchEn (warnLatchEn),
    .clear   (clear_reg),
    .flags   (warnFlag)
  );

  // Status images; reserved positions are constant zero.
  reg_byte_t channelImg;
  reg_byte_t global1Img;
  reg_byte_t global2Img;
  reg_byte_t warningImg;

  always_comb begin
    channelImg = `RST_STATUS;
    channelImg[`BIT_LEFT_DC]  = faultFlag.left_dc_fault_flag;
    channelImg[`BIT_RIGHT_DC] = faultFlag.right_dc_fault_flag;
    channelImg[`BIT_LEFT_OC]  = faultFlag.left_overcurrent_flag;
    channelImg[`BIT_RIGHT_OC] = faultFlag.right_overcurrent_flag;
  end

  always_comb begin
    global1Img = `RST_STATUS;
    global1Img[`BIT_OTP_CRC]     = digitalStatus.otpCrcError;
    global1Img[`BIT_BIQUAD_WR]   = digitalStatus.biquad_write_error_flag;
    global1Img[`BIT_EEPROM_LOAD] = digitalStatus.eepromLoadError;
    global1Img[`BIT_CLOCK_FAULT] = faultFlag.clock_fault;
    global1Img[`BIT_PVDD_OV]     = faultFlag.power_supply_overvoltage_flag;
    global1Img[`BIT_PVDD_UV]     = faultFlag.power_supply_undervoltage_flag;
  end

  always_comb begin
    global2Img = `RST_STATUS;
    global2Img[`BIT_RIGHT_CBC]  = faultFlag.right_current_limit_fault_flag;
    global2Img[`BIT_LEFT_CBC]   = faultFlag.left_current_limit_fault_flag;
    global2Img[`BIT_THERMAL_SD] = faultFlag.thermal_shutdown_flag;
  end

  always_comb begin
    warningImg = `RST_STATUS;
    warningImg[`BIT_LEFT_CBCW]  = warnFlag.left_current_limit_warning_flag;
    warningImg[`BIT_RIGHT_CBCW] = warnFlag.right_current_limit_warning_flag;
    warningImg[`BIT_OTW_LEVEL_HI:`BIT_OTW_LEVEL_LO] = {
      warnFlag.thermal_warning_level_four,
      warnFlag.thermal_warning_level_three,
      warnFlag.thermal_warning_level_two,
      warnFlag.thermal_warning_level_one
    };
  end

  // Read multiplexer; unmapped and write-only addresses read zero.
  assign rdData_next =
    selChannel ? channelImg   :
    selGlobal1 ? global1Img   :
    selGlobal2 ? global2Img   :
    selWarning ? warningImg   :
    selMask    ? maskCtl_reg  :
    selLatch   ? latchCtl_reg :
                 `RST_STATUS;

  // Read data is captured only when a read is taken, so it holds between
  // answers and a late poll still sees the last value.
  always_ff @(posedge clk) begin
    if (srst) begin
      rdValid_reg <= 1'b0;
      rdData_reg  <= `RST_STATUS;
    end else begin
      rdValid_reg <= regReq.rdEn;
      if (regReq.rdEn) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  assign rdValid = rdValid_reg;
  assign rdData  = rdData_reg;

  // Report gating. Masks only hide the report; the status bits still show
  // the condition so software can poll any masked fault but a logic supply one, which has no status bit.
  wire maskThermSd = maskCtl_reg[`BIT_MASK_THERMAL_SD];
  wire maskLogicUv = maskCtl_reg[`BIT_MASK_LOGIC_UV];
  wire maskLogicOv = maskCtl_reg[`BIT_MASK_LOGIC_OV];
  wire maskClock   = maskCtl_reg[`BIT_MASK_CLOCK];
  wire maskPower   = maskCtl_reg[`BIT_MASK_POWER];
  wire maskDc      = maskCtl_reg[`BIT_DC_REPORT_MASK];
  wire maskOc      = maskCtl_reg[`BIT_OC_REPORT_MASK];
  wire maskCbcF    = latchCtl_reg[`BIT_MASK_CBC_FAULT];
  wire maskCbcW    = latchCtl_reg[`BIT_MASK_CBC_WARN];
  wire maskThermW  = latchCtl_reg[`BIT_MASK_THERMAL_WARN];

  wire repThermSd = faultFlag.thermal_shutdown_flag & ~maskThermSd;
  wire repLogic   = (faultFlag.logic_supply_undervoltage & ~maskLogicUv)
                  | (faultFlag.logic_supply_overvoltage & ~maskLogicOv);
  wire repClock   = faultFlag.clock_fault & ~maskClock;
  wire repPower   = (faultFlag.power_supply_undervoltage_flag
                  | faultFlag.power_supply_overvoltage_flag) & ~maskPower;
  wire repDc      = (faultFlag.left_dc_fault_flag
                  | faultFlag.right_dc_fault_flag) & ~maskDc;
  wire repOc      = (faultFlag.left_overcurrent_flag
                  | faultFlag.right_overcurrent_flag) & ~maskOc;
  wire repCbcF    = (faultFlag.left_current_limit_fault_flag
                  | faultFlag.right_current_limit_fault_flag) & ~maskCbcF;
  wire repCbcW    = (warnFlag.left_current_limit_warning_flag
                  | warnFlag.right_current_limit_warning_flag) & ~maskCbcW;
  wire repThermW  = (warnFlag.thermal_warning_level_four
                  | warnFlag.thermal_warning_level_three
                  | warnFlag.thermal_warning_level_two
                  | warnFlag.thermal_warning_level_one) & ~maskThermW;

  wire faultReport_next = repThermSd | repLogic | repClock | repPower
                        | repDc | repOc | repCbcF;
  wire warnReport_next  = repCbcW | repThermW;

  logic faultReport_reg;
  logic warnReport_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      faultReport_reg <= 1'b0;
      warnReport_reg  <= 1'b0;
    end else begin
      faultReport_reg <= faultReport_next;
      warnReport_reg  <= warnReport_next;
    end
  end

  assign faultReport      = faultReport_reg;
  assign warnReport       = warnReport_reg;
  assign analogFaultClear = clear_reg;

endmodule : amp_fault_status_mask
`default_nettype wire

// *** shared/amp_fault_cfg.svh ***
// Offsets, bit positions and reset values of the fault status and mask bank.
`ifndef AMP_FAULT_CFG_SVH
`define AMP_FAULT_CFG_SVH

`define OFS_CHANNEL_FAULT_STATUS    8'h70
`define OFS_GLOBAL_FAULT_STATUS_ONE 8'h71
`define OFS_GLOBAL_FAULT_STATUS_TWO 8'h72
`define OFS_WARNING_STATUS          8'h73
`define OFS_FAULT_REPORT_MASK       8'h74
`define OFS_FAULT_LATCH_CONTROL     8'h75
`define OFS_FAULT_CLEAR             8'h78

`define RST_STATUS                  8'h00
`define RST_FAULT_REPORT_MASK       8'h00
`define RST_FAULT_LATCH_CONTROL     8'hF8

// Channel fault status bits.
`define BIT_LEFT_DC                 3
`define BIT_RIGHT_DC                2
`define BIT_LEFT_OC                 1
`define BIT_RIGHT_OC                0
// Global fault status one bits.
`define BIT_OTP_CRC                 7
`define BIT_BIQUAD_WR               6
`define BIT_EEPROM_LOAD             5
`define BIT_CLOCK_FAULT             2
`define BIT_PVDD_OV                 1
`define BIT_PVDD_UV                 0
// Global fault status two bits.
`define BIT_RIGHT_CBC               2
`define BIT_LEFT_CBC                1
`define BIT_THERMAL_SD              0
// Warning status bits.
`define BIT_LEFT_CBCW               5
`define BIT_RIGHT_CBCW              4
`define BIT_OTW_LEVEL_HI            3
`define BIT_OTW_LEVEL_LO            0
// Fault report mask bits; bit 3 is reserved.
`define BIT_MASK_THERMAL_SD         7
`define BIT_MASK_LOGIC_UV           6
`define BIT_MASK_LOGIC_OV           5
`define BIT_MASK_CLOCK              4
`define BIT_MASK_RESERVED           3
`define BIT_MASK_POWER              2
`define BIT_DC_REPORT_MASK          1
`define BIT_OC_REPORT_MASK          0
// Fault latch control bits.
`define BIT_LATCH_CBC_FAULT         7
`define BIT_LATCH_CBC_WARN          6
`define BIT_LATCH_CLOCK             5
`define BIT_LATCH_THERMAL_SD        4
`define BIT_LATCH_THERMAL_WARN      3
`define BIT_MASK_THERMAL_WARN       2
`define BIT_MASK_CBC_WARN           1
`define BIT_MASK_CBC_FAULT          0
// Fault clear register bit.
`define BIT_ANALOG_FAULT_CLEAR      7

`define SYNC_STAGES                 2

`endif

// *** shared/amp_fault_pkg.sv ***
// Types shared by the fault status and mask bank.
`default_nettype none
package amp_fault_pkg;

  typedef logic [7:0] reg_byte_t;

  // Fault conditions from the analog monitors, all levels.
  typedef struct packed {
    logic thermal_shutdown_flag;
    logic right_current_limit_fault_flag;
    logic left_current_limit_fault_flag;
    logic logic_supply_overvoltage;
    logic logic_supply_undervoltage;
    logic clock_fault;
    logic power_supply_overvoltage_flag;
    logic power_supply_undervoltage_flag;
    logic left_dc_fault_flag;
    logic right_dc_fault_flag;
    logic left_overcurrent_flag;
    logic right_overcurrent_flag;
  } fault_in_s;

  // Warning conditions from the analog monitors, all levels.
  typedef struct packed {
    logic left_current_limit_warning_flag;
    logic right_current_limit_warning_flag;
    logic thermal_warning_level_four;
    logic thermal_warning_level_three;
    logic thermal_warning_level_two;
    logic thermal_warning_level_one;
  } warn_in_s;

  // Digital status from the control clock domain.
  typedef struct packed {
    logic otpCrcError;
    logic biquad_write_error_flag;
    logic eepromLoadError;
  } digital_status_s;

  // Register port request.
  typedef struct packed {
    logic      wrEn;
    logic      rdEn;
    reg_byte_t addr;
    reg_byte_t wData;
  } reg_req_s;

endpackage : amp_fault_pkg
`default_nettype wire

// *** core/fault_sync.sv ***
// Two-stage synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
`include "amp_fault_cfg.svh"
module fault_sync #(
  parameter int WIDTH  = 1,
  parameter int STAGES = `SYNC_STAGES
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  if (WIDTH < 1 || STAGES < 2) begin : gBadParams
    $error("fault_sync needs WIDTH >= 1 and STAGES >= 2");
  end

  logic [STAGES-1:0][WIDTH-1:0] stage_reg;

  // Only the next stage reads the first one.
  always_ff @(posedge clk) begin
    if (srst) begin
      stage_reg <= '0;
    end else begin
      stage_reg <= {stage_reg[STAGES-2:0], asyncIn};
    end
  end

  assign syncOut = stage_reg[STAGES-1];

endmodule : fault_sync
`default_nettype wire

// *** core/fault_latch.sv ***
// Per-bit sticky fault flags with latch enable and a common clear.
`timescale 1ns/1ps
`default_nettype none
module fault_latch #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Condition and control
  input  wire logic [WIDTH-1:0] live,
  input  wire logic [WIDTH-1:0] latchEn,
  input  wire logic             clear,
  // Flags
  output logic      [WIDTH-1:0] flags
);

  if (WIDTH < 1) begin : gBadWidth
    $error("fault_latch needs WIDTH >= 1");
  end

  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] flag_next;

  // A live condition always sets the flag, so a fault during clear is kept.
  for (genvar i = 0; i < WIDTH; i++) begin : gBit
    assign flag_next[i] = live[i] | (latchEn[i] & flag_reg[i] & ~clear);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flags = flag_reg;

endmodule : fault_latch
`default_nettype wire

// *** bench/amp_fault_status_mask_properties.sv ***
// Port checker of the fault status and mask bank.
`timescale 1ns/1ps
`default_nettype none
module amp_fault_status_mask_properties
  import amp_fault_pkg::*;
(
  // Clock and reset
  input wire logic            clk,
  input wire logic            srst,
  // Register port
  input wire reg_req_s        regReq,
  input wire logic            rdValid,
  input wire reg_byte_t       rdData,
  // Monitor conditions
  input wire fault_in_s       faultIn,
  input wire warn_in_s        warnIn,
  input wire digital_status_s digitalStatus,
  // Reports
  input wire logic            faultReport,
  input wire logic            warnReport,
  input wire logic            analogFaultClear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  reg_byte_t maskCopy_reg;
  reg_byte_t latchCopy_reg;
  reg_byte_t rdAddr_reg;
  logic      clrReq;

  assign clrReq = regReq.wrEn && regReq.addr == 8'h78 && regReq.wData[7];

  // Shadow copies of the two writable registers, so reports can be judged against masks.
  always_ff @(posedge clk) begin
    if (srst) begin
      maskCopy_reg  <= 8'h00;
      latchCopy_reg <= 8'hF8;
    end else if (regReq.wrEn && regReq.addr == 8'h74) begin
      maskCopy_reg <= regReq.wData & 8'hF7;
    end else if (regReq.wrEn && regReq.addr == 8'h75) begin
      latchCopy_reg <= regReq.wData;
    end
  end

  always_ff @(posedge clk) begin
    if (regReq.rdEn) begin
      rdAddr_reg <= regReq.addr;
    end
  end

  // Bits that must read zero; unmapped places read zero entirely.
  function automatic reg_byte_t resv(reg_byte_t a);
    case (a)
      8'h70: return 8'hF0;
      8'h71: return 8'h18;
      8'h72: return 8'hF8;
      8'h73: return 8'hC0;
      8'h74: return 8'h08;
      8'h75: return 8'h00;
      default: return 8'hFF;
    endcase
  endfunction : resv

  sequence dcOnset;
    $rose(faultIn.left_dc_fault_flag) && !maskCopy_reg[1];
  endsequence
  sequence dcHeld;
    (faultIn.left_dc_fault_flag && !regReq.wrEn)[*4];
  endsequence

  a_read_answer: assert property (regReq.rdEn |=> rdValid)
    else $error("read not answered");
  a_no_spurious: assert property (!regReq.rdEn |=> !rdValid)
    else $error("answer without read");
  a_data_holds: assert property (!rdValid |-> $stable(rdData))
    else $error("read data moved");
  a_reserved_zero: assert property (rdValid |-> (rdData & resv(rdAddr_reg)) == 8'h00)
    else $error("reserved bit read nonzero");
  a_mask_readback: assert property (rdValid && rdAddr_reg == 8'h74 |->
    rdData == $past(maskCopy_reg))
    else $error("mask register readback wrong");
  a_clear_pulse: assert property (clrReq |=> analogFaultClear)
    else $error("clear pulse missing");
  a_clear_cause: assert property (analogFaultClear |-> $past(clrReq))
    else $error("clear pulse without write");
  a_report_onset: assert property (dcOnset ##0 dcHeld |=> faultReport)
    else $error("fault report late");
  a_fault_masked: assert property ((maskCopy_reg[7:4] == 4'hF
    && maskCopy_reg[2:0] == 3'h7 && latchCopy_reg[0])[*2] |-> !faultReport)
    else $error("masked fault reported");
  a_warn_masked: assert property ((latchCopy_reg[2:1] == 2'b11)[*2] |-> !warnReport)
    else $error("masked warning reported");
endmodule : amp_fault_status_mask_properties

bind amp_fault_status_mask amp_fault_status_mask_properties i_props (
  .clk(clk), .srst(srst), .regReq(regReq), .rdValid(rdValid), .rdData(rdData),
  .faultIn(faultIn), .warnIn(warnIn), .digitalStatus(digitalStatus),
  .faultReport(faultReport), .warnReport(warnReport), .analogFaultClear(analogFaultClear));
`default_nettype wire

// *** bench/tb_amp_fault_status_mask.sv ***
// Self-checking bench of the fault status and mask bank.
`timescale 1ns/1ps
`default_nettype none
module tb_amp_fault_status_mask
  import amp_fault_pkg::*;
;
  logic            clk;
  logic            srst;
  reg_req_s        regReq;
  logic            rdValid;
  reg_byte_t       rdData;
  fault_in_s       faultIn;
  warn_in_s        warnIn;
  digital_status_s digitalStatus;
  logic            faultReport;
  logic            warnReport;
  logic            analogFaultClear;
  logic            clrSeen;
  logic [17:0]     src;
  reg_byte_t       got;
  reg_byte_t       m74;
  reg_byte_t       m75;
  int              err_count;
  int              checked;
  int              cycles;

  amp_fault_status_mask i_dut (.clk(clk), .srst(srst), .regReq(regReq), .rdValid(rdValid),
    .rdData(rdData), .faultIn(faultIn), .warnIn(warnIn), .digitalStatus(digitalStatus),
    .faultReport(faultReport), .warnReport(warnReport), .analogFaultClear(analogFaultClear));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count = err_count + 1;
      $display("unexpected at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_byte(reg_byte_t g, reg_byte_t e, string what);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, g, e);
    end
  endtask : chk_byte

  task automatic chk_bit(logic g, logic e, string what);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %b want %b", $time, what, g, e);
    end
  endtask : chk_bit

  task automatic idle();
    @(posedge clk);
    #1;
  endtask : idle

  // The strobe is dropped one edge before the next request may raise it again.
  task automatic wr(reg_byte_t a, reg_byte_t d);
    regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wData: d};
    idle();
    clrSeen = analogFaultClear;
    regReq.wrEn = 1'b0;
    idle();
  endtask : wr

  task automatic rdchk(reg_byte_t a, reg_byte_t e, string what);
    regReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wData: 8'h00};
    idle();
    regReq.rdEn = 1'b0;
    chk_bit(rdValid, 1'b1, "read answer");
    chk_byte(rdData, e, what);
    idle();
  endtask : rdchk

  // Source vector: warnings in bits 17-12, faults in bits 11-0, struct order.
  function automatic reg_byte_t expStatus(reg_byte_t a, logic [17:0] s, digital_status_s d);
    case (a)
      8'h70: return {4'h0, s[3:0]};
      8'h71: return {d, 2'b00, s[6:4]};
      8'h72: return {5'h00, s[10:9], s[11]};
      8'h73: return {2'b00, s[17:12]};
      default: return 8'h00;
    endcase
  endfunction : expStatus

  function automatic logic [1:0] expReport(logic [17:0] s, reg_byte_t m, reg_byte_t c);
    logic fr;
    logic wn;
    fr = (|s[1:0] & ~m[0]) | (|s[3:2] & ~m[1]) | (|s[5:4] & ~m[2]) | (s[6] & ~m[4])
       | (s[7] & ~m[6]) | (s[8] & ~m[5]) | (|s[10:9] & ~c[0]) | (s[11] & ~m[7]);
    wn = (|s[17:16] & ~c[1]) | (|s[15:12] & ~c[2]);
    return {fr, wn};
  endfunction : expReport

  task automatic drive(logic [17:0] s);
    src = s;
    faultIn = s[11:0];
    warnIn = s[17:12];
  endtask : drive

  task automatic chkAll(logic [17:0] s);
    for (int a = 8'h70; a <= 8'h73; a++) begin
      rdchk(8'(a), expStatus(8'(a), s, digitalStatus), "status");
    end
  endtask : chkAll

  initial begin
    err_count = 0;
    checked = 0;
    cycles = 0;
    clrSeen = 1'b0;
    regReq = '0;
    digitalStatus = '0;
    drive(18'h00000);
    srst = 1'b1;
    void'($urandom(39837));
    repeat (12) @(posedge clk);
    #1;
    srst = 1'b0;
    for (int a = 8'h70; a <= 8'h78; a++) begin
      rdchk(8'(a), (a == 8'h75) ? 8'hF8 : 8'h00, "reset value");
    end
    rdchk(8'($urandom_range(0, 8'h6F)), 8'h00, "unmapped");
    $display("test reset done");
    for (int n = 0; n < 10; n++) begin
      m74 = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : 8'($urandom);
      wr(8'h74, m74);
      rdchk(8'h74, m74 & 8'hF7, "mask");
      wr(8'h75, m74);
      rdchk(8'h75, m74, "latch control");
      wr(8'h70 + 8'($urandom_range(0, 3)), m74);
      chkAll(18'h00000);
      wr(8'h78, 8'h7F);
      chk_bit(clrSeen, 1'b0, "clear without bit 7");
    end
    wr(8'h74, 8'h00);
    wr(8'h75, 8'hF8);
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      digitalStatus = 3'(k);
      rdchk(8'h71, {3'(k), 5'h00}, "digital status");
    end
    digitalStatus = '0;
    $display("test digital status done");
    for (int i = 0; i < 18; i++) begin
      drive(18'h00001 << i);
      repeat (5) idle();
      chk_bit(faultReport, i < 12, "fault report");
      chk_bit(warnReport, i >= 12, "warn report");
      wr(8'h78, 8'h80);
      chk_bit(clrSeen, 1'b1, "clear pulse");
      chkAll(src);
      drive(18'h00000);
      repeat (4) idle();
      chkAll(18'h00001 << i);
      wr(8'h78, 8'h80);
      repeat (2) idle();
      chkAll(18'h00000);
    end
    $display("test bit map done");
    wr(8'h75, 8'h00);
    drive(18'h00800);
    repeat (5) idle();
    rdchk(8'h72, 8'h01, "unlatched set");
    drive(18'h00000);
    repeat (5) idle();
    rdchk(8'h72, 8'h00, "unlatched follows");
    wr(8'h75, 8'hF8);
    $display("test latch enable done");
    for (int n = 0; n < 20; n++) begin
      m74 = (n == 0) ? 8'hFF : 8'($urandom);
      m75 = (n == 0) ? 8'hFF : 8'hF8 | 8'($urandom_range(0, 7));
      digitalStatus = 3'($urandom);
      wr(8'h74, m74);
      wr(8'h75, m75);
      drive(18'($urandom));
      repeat (5) idle();
      chk_byte({6'h00, faultReport, warnReport}, {6'h00, expReport(src, m74, m75)},
        "masked reports");
      chkAll(src);
      drive(18'h00000);
      repeat (4) idle();
      wr(8'h78, 8'h80);
      repeat (2) idle();
      chkAll(18'h00000);
    end
    $display("test random masks done");
    wr(8'h74, 8'hFF);
    wr(8'h75, 8'h00);
    drive(18'h3FFFF);
    repeat (5) idle();
    srst = 1'b1;
    repeat (3) idle();
    srst = 1'b0;
    chk_bit(faultReport, 1'b0, "report after reset");
    chk_bit(warnReport, 1'b0, "warn after reset");
    rdchk(8'h70, 8'h00, "status after reset");
    rdchk(8'h74, 8'h00, "mask after reset");
    rdchk(8'h75, 8'hF8, "latch after reset");
    drive(18'h00000);
    $display("test mid reset done");
    give_verdict();
  end
endmodule : tb_amp_fault_status_mask
`default_nettype wire
